/* File: core/spimsp_defs.svh */
// Purpose: Offsets, field positions, reset values and rate counts
// Assumes: Included by the serial port design and test bench
// Notes: Register indices are word aligned on the plain port
`ifndef SPIMSP_DEFS_SVH
`define SPIMSP_DEFS_SVH

`define SPIMSP_ADDR_W 4
`define SPIMSP_OFS_CTRL 4'h0
`define SPIMSP_OFS_STAT 4'h4
`define SPIMSP_OFS_DATA 4'h8
`define SPIMSP_OFS_DDR 4'hC

`define SPIMSP_BIT_IRQ_EN 7
`define SPIMSP_BIT_PORT_EN 6
`define SPIMSP_BIT_LSB_FIRST 5
`define SPIMSP_BIT_MASTER 4
`define SPIMSP_BIT_CLOCK_POLARITY 3
`define SPIMSP_BIT_CLOCK_PHASE 2

`define SPIMSP_BIT_XFER_DONE 7
`define SPIMSP_BIT_WRITE_COLLISION_FLAG 6
`define SPIMSP_BIT_DBL_SPEED 0

`define SPIMSP_DDR_MOSI 0
`define SPIMSP_DDR_MISO 1
`define SPIMSP_DDR_SCK 2
`define SPIMSP_DDR_SS 3

`define SPIMSP_CTRL_RESET 8'h00
`define SPIMSP_STAT_RESET 8'h00
`define SPIMSP_DDR_RESET 4'h0

`define SPIMSP_HALF_DIV4 8'h02
`define SPIMSP_HALF_DIV16 8'h08
`define SPIMSP_HALF_DIV64 8'h20
`define SPIMSP_HALF_DIV128 8'h40
`define SPIMSP_HALF_DIV2 8'h01
`define SPIMSP_HALF_DIV8 8'h04
`define SPIMSP_HALF_DIV32 8'h10

`endif

/* File: core/spimsp_pkg.sv */
// Purpose: Types shared by the serial port block
// Assumes: Nothing beyond the defs header
// Notes: Types only; numbers live in the header
package spimsp_pkg;
   typedef enum logic [1:0] {
      SPIMSP_IDLE,
      SPIMSP_LEAD,
      SPIMSP_TRAIL
   } spimsp_mstate_t;
endpackage

/* File: core/spimsp_top.sv */
// Purpose: Byte-wide serial peripheral port, master or slave
// Assumes: Inputs synchronous to mclk except slave sck and ss
// Notes: Slave sck phases must exceed three mclk periods
`include "spimsp_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module spimsp_top
   import spimsp_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Register port
   input wire logic [`SPIMSP_ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Interrupt handshake with the core
   input wire logic global_irq_enable,
   input wire logic irq_vector_ack,
   output logic xfer_irq,
   // Pins
   input wire logic mosi_in,
   output logic mosi_out,
   output logic mosi_oe,
   input wire logic miso_in,
   output logic miso_out,
   output logic miso_oe,
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe,
   input wire logic ss_n_in,
   output logic ss_n_out,
   output logic ss_n_oe,
   // General-purpose pin values used when a pin is user-defined
   input wire logic [3:0] gpio_out
);

   logic [7:0] ctrl_q;
   logic dbl_q;
   logic done_q, write_collision_flag_q;
   logic [3:0] ddr_q;
   logic [7:0] shift_q, rxbuf_q, rdata_q;
   logic [2:0] bitcnt_q;
   logic [7:0] divcnt_q;
   logic stat_seen_q;
   spimsp_mstate_t mstate_q;
   logic sck_q;
   logic sck_s1_q, sck_s2_q, sck_s3_q;
   logic ss_s1_q, ss_s2_q;
   logic mosi_q, miso_q;
   logic mosi_oe_q, miso_oe_q, sck_oe_q, ss_oe_q;
   logic irq_q;

   logic en, mst, clock_polarity, clock_phase, lsbf;
   logic wr_ctrl, wr_stat, wr_data, rd_stat, rd_data;
   logic [7:0] half_div;
   logic demote, busy, ss_low;
   logic s_lead, s_trail, s_active;
   logic byte_done_m, byte_done_s, last_bit, m_end;
   logic [7:0] stat_val;

   assign en = ctrl_q[`SPIMSP_BIT_PORT_EN];
   assign mst = ctrl_q[`SPIMSP_BIT_MASTER];
   assign clock_polarity = ctrl_q[`SPIMSP_BIT_CLOCK_POLARITY];
   assign clock_phase = ctrl_q[`SPIMSP_BIT_CLOCK_PHASE];
   assign lsbf = ctrl_q[`SPIMSP_BIT_LSB_FIRST];

   assign wr_ctrl = reg_wr && reg_addr == `SPIMSP_OFS_CTRL;
   assign wr_stat = reg_wr && reg_addr == `SPIMSP_OFS_STAT;
   assign wr_data = reg_wr && reg_addr == `SPIMSP_OFS_DATA;
   assign rd_stat = reg_rd && reg_addr == `SPIMSP_OFS_STAT;
   assign rd_data = reg_rd && reg_addr == `SPIMSP_OFS_DATA;

   // Master ss input is sampled directly; it is a level, not a clock
   assign ss_low = !ss_n_in;
   assign demote = en && mst && !ddr_q[`SPIMSP_DDR_SS] && ss_low;
   assign busy = mst ? (mstate_q != SPIMSP_IDLE) : s_active;
   assign last_bit = bitcnt_q == 3'h7;

   // Half period of sck in mclk cycles
   always_comb begin
      unique case ({dbl_q, ctrl_q[1:0]})
         3'b000: half_div = `SPIMSP_HALF_DIV4;
         3'b001: half_div = `SPIMSP_HALF_DIV16;
         3'b010: half_div = `SPIMSP_HALF_DIV64;
         3'b011: half_div = `SPIMSP_HALF_DIV128;
         3'b100: half_div = `SPIMSP_HALF_DIV2;
         3'b101: half_div = `SPIMSP_HALF_DIV8;
         3'b110: half_div = `SPIMSP_HALF_DIV32;
         3'b111: half_div = `SPIMSP_HALF_DIV64;
      endcase
   end

   // Slave inputs: two flops, sck edges looked at past the second flop
   always_ff @(posedge mclk) begin
      if (srst) begin
         sck_s1_q <= 1'b0;
         sck_s2_q <= 1'b0;
         sck_s3_q <= 1'b0;
         ss_s1_q <= 1'b1;
         ss_s2_q <= 1'b1;
      end else begin
         sck_s1_q <= sck_in;
         sck_s2_q <= sck_s1_q;
         sck_s3_q <= sck_s2_q;
         ss_s1_q <= ss_n_in;
         ss_s2_q <= ss_s1_q;
      end
   end

   assign s_active = en && !mst && !ss_s2_q;
   // Leading edge leaves the idle level; trailing returns to it
   assign s_lead = s_active && (sck_s2_q != sck_s3_q) && (sck_s2_q != clock_polarity);
   assign s_trail = s_active && (sck_s2_q != sck_s3_q) && (sck_s2_q == clock_polarity);
   assign byte_done_s = last_bit && (clock_phase ? s_trail : s_lead);

   // Control register; hardware clears master on demotion
   always_ff @(posedge mclk) begin
      if (srst) begin
         ctrl_q <= `SPIMSP_CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_q <= reg_wdata;
      end else if (demote) begin
         ctrl_q[`SPIMSP_BIT_MASTER] <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         dbl_q <= 1'b0;
         ddr_q <= `SPIMSP_DDR_RESET;
      end else begin
         if (wr_stat) begin
            dbl_q <= reg_wdata[`SPIMSP_BIT_DBL_SPEED];
         end
         if (reg_wr && reg_addr == `SPIMSP_OFS_DDR) begin
            ddr_q <= reg_wdata[3:0];
         end
      end
   end

   // Flags: set wins over clear
   always_ff @(posedge mclk) begin
      if (srst) begin
         done_q <= 1'b0;
         write_collision_flag_q <= 1'b0;
         stat_seen_q <= 1'b0;
      end else begin
         if (rd_stat) begin
            stat_seen_q <= done_q || write_collision_flag_q;
         end else if (rd_data || wr_data) begin
            stat_seen_q <= 1'b0;
         end
         if (byte_done_m || byte_done_s || demote) begin
            done_q <= 1'b1;
         end else if (irq_vector_ack ||
                      (stat_seen_q && (rd_data || wr_data))) begin
            done_q <= 1'b0;
         end
         if (wr_data && busy) begin
            write_collision_flag_q <= 1'b1;
         end else if (stat_seen_q && (rd_data || wr_data)) begin
            write_collision_flag_q <= 1'b0;
         end
      end
   end

   // Master engine
   // With leading-edge sampling the counter has already wrapped to zero
   // by the last trailing edge, so the end test depends on the phase
   assign m_end = clock_phase ? last_bit : (bitcnt_q == 3'h0);
   assign byte_done_m = mstate_q == SPIMSP_TRAIL && divcnt_q == 8'h01 &&
                        m_end;
   always_ff @(posedge mclk) begin
      if (srst || !en || !mst || demote) begin
         mstate_q <= SPIMSP_IDLE;
         divcnt_q <= 8'h00;
         sck_q <= 1'b0;
      end else begin
         unique case (mstate_q)
            SPIMSP_IDLE: begin
               sck_q <= clock_polarity;
               if (wr_data) begin
                  mstate_q <= SPIMSP_LEAD;
                  divcnt_q <= half_div;
               end
            end
            SPIMSP_LEAD: begin
               if (divcnt_q == 8'h01) begin
                  sck_q <= !clock_polarity;
                  mstate_q <= SPIMSP_TRAIL;
                  divcnt_q <= half_div;
               end else begin
                  divcnt_q <= divcnt_q - 8'h01;
               end
            end
            SPIMSP_TRAIL: begin
               if (divcnt_q == 8'h01) begin
                  sck_q <= clock_polarity;
                  mstate_q <= m_end ? SPIMSP_IDLE : SPIMSP_LEAD;
                  divcnt_q <= half_div;
               end else begin
                  divcnt_q <= divcnt_q - 8'h01;
               end
            end
         endcase
      end
   end

   // Shifter, shared by both modes
   logic m_lead, m_trail, do_sample, do_shift;
   logic in_bit;
   assign m_lead = mstate_q == SPIMSP_LEAD && divcnt_q == 8'h01;
   assign m_trail = mstate_q == SPIMSP_TRAIL && divcnt_q == 8'h01;
   assign in_bit = mst ? miso_in : mosi_in;
   // Sample on one edge, shift on the other
   assign do_sample = mst ? (clock_phase ? m_trail : m_lead)
                          : (clock_phase ? s_trail : s_lead);
   assign do_shift = mst ? (clock_phase ? m_lead : m_trail)
                         : (clock_phase ? s_lead : s_trail);

   always_ff @(posedge mclk) begin
      if (srst) begin
         shift_q <= 8'h00;
         bitcnt_q <= 3'h0;
         rxbuf_q <= 8'h00;
         mosi_q <= 1'b0;
         miso_q <= 1'b0;
      end else if (!en || (!mst && ss_s2_q)) begin
         bitcnt_q <= 3'h0;
         if (wr_data) begin
            shift_q <= reg_wdata;
         end
         miso_q <= lsbf ? (wr_data ? reg_wdata[0] : shift_q[0])
                        : (wr_data ? reg_wdata[7] : shift_q[7]);
      end else begin
         // Collided writes leave the shifter alone
         if (wr_data && !busy) begin
            shift_q <= reg_wdata;
            mosi_q <= lsbf ? reg_wdata[0] : reg_wdata[7];
            miso_q <= lsbf ? reg_wdata[0] : reg_wdata[7];
         end else if (do_sample) begin
            shift_q <= lsbf ? {in_bit, shift_q[7:1]}
                            : {shift_q[6:0], in_bit};
            bitcnt_q <= bitcnt_q + 3'h1;
            if (last_bit) begin
               rxbuf_q <= lsbf ? {in_bit, shift_q[7:1]}
                               : {shift_q[6:0], in_bit};
               bitcnt_q <= 3'h0;
            end
         end else if (do_shift && bitcnt_q != 3'h0) begin
            mosi_q <= lsbf ? shift_q[0] : shift_q[7];
            miso_q <= lsbf ? shift_q[0] : shift_q[7];
         end
      end
   end

   // Pin drivers
   always_ff @(posedge mclk) begin
      if (srst) begin
         mosi_oe_q <= 1'b0;
         miso_oe_q <= 1'b0;
         sck_oe_q <= 1'b0;
         ss_oe_q <= 1'b0;
      end else if (!en) begin
         mosi_oe_q <= ddr_q[`SPIMSP_DDR_MOSI];
         miso_oe_q <= ddr_q[`SPIMSP_DDR_MISO];
         sck_oe_q <= ddr_q[`SPIMSP_DDR_SCK];
         ss_oe_q <= ddr_q[`SPIMSP_DDR_SS];
      end else if (mst && !demote) begin
         mosi_oe_q <= ddr_q[`SPIMSP_DDR_MOSI];
         miso_oe_q <= 1'b0;
         sck_oe_q <= ddr_q[`SPIMSP_DDR_SCK];
         ss_oe_q <= ddr_q[`SPIMSP_DDR_SS];
      end else begin
         mosi_oe_q <= 1'b0;
         miso_oe_q <= ddr_q[`SPIMSP_DDR_MISO] && !ss_s2_q;
         sck_oe_q <= 1'b0;
         ss_oe_q <= 1'b0;
      end
   end

   // Read data and interrupt request
   assign stat_val = {done_q, write_collision_flag_q, 5'h00, dbl_q};
   always_ff @(posedge mclk) begin
      if (srst) begin
         rdata_q <= 8'h00;
         irq_q <= 1'b0;
      end else begin
         irq_q <= ctrl_q[`SPIMSP_BIT_IRQ_EN] && done_q &&
                  global_irq_enable && !irq_vector_ack;
         if (reg_rd) begin
            unique case (reg_addr)
               `SPIMSP_OFS_CTRL: rdata_q <= ctrl_q;
               `SPIMSP_OFS_STAT: rdata_q <= stat_val;
               `SPIMSP_OFS_DATA: rdata_q <= rxbuf_q;
               `SPIMSP_OFS_DDR: rdata_q <= {4'h0, ddr_q};
               default: rdata_q <= 8'h00;
            endcase
         end else begin
            rdata_q <= 8'h00;
         end
      end
   end

   assign reg_rdata = rdata_q;
   assign xfer_irq = irq_q;
   // Master with ss as output: ss pin is plain gpio
   assign mosi_out = (en && mst) ? mosi_q : gpio_out[`SPIMSP_DDR_MOSI];
   assign miso_out = en ? miso_q : gpio_out[`SPIMSP_DDR_MISO];
   assign sck_out = (en && mst) ? sck_q : gpio_out[`SPIMSP_DDR_SCK];
   assign ss_n_out = gpio_out[`SPIMSP_DDR_SS];
   assign mosi_oe = mosi_oe_q;
   assign miso_oe = miso_oe_q;
   assign sck_oe = sck_oe_q;
   assign ss_n_oe = ss_oe_q;

endmodule
`default_nettype wire

/* File: tb/spimsp_peer.sv */
// Purpose: Far-side slave model for the serial port block
// Assumes: Frame format given by the bench before select falls
// Notes: Released miso shows the inverse of its last bit
`timescale 1ns/10ps
`default_nettype none
module spimsp_peer (
   // Link pins
   input wire logic sck,
   input wire logic mosi,
   input wire logic ss_n,
   // Format and data
   input wire logic clock_polarity,
   input wire logic clock_phase,
   input wire logic lsb,
   input wire logic [7:0] tx,
   output logic miso,
   output logic [7:0] rx
);
   int k = 0;
   initial miso = 1'b0;
   initial rx = 8'h00;
   always @(negedge ss_n) begin
      k = 0;
      miso = lsb ? tx[0] : tx[7];
   end
   // A stale bit could pass for real data, so flip it
   always @(posedge ss_n) miso = ~miso;
   always @(sck) begin
      if (!ss_n && k < 8) begin
         if (sck == !(clock_polarity ^ clock_phase)) begin
            rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
            k++;
         end else
            miso = lsb ? tx[k] : tx[7 - k];
      end
   end
endmodule
`default_nettype wire

/* File: tb/spimsp_asserts.sv */
// Purpose: Port checks for the serial port block
// Assumes: Master mode shows as sck_oe high
// Notes: Bound to spimsp_top below
`timescale 1ns/10ps
`default_nettype none
module spimsp_asserts (
   // Clock, reset and bus
   input wire logic mclk,
   input wire logic srst,
   input wire logic [3:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Interrupt
   input wire logic global_irq_enable,
   input wire logic irq_vector_ack,
   input wire logic xfer_irq,
   // Pins
   input wire logic mosi_oe,
   input wire logic miso_oe,
   input wire logic sck_oe,
   input wire logic ss_n_in,
   input wire logic ss_n_out,
   input wire logic ss_n_oe,
   input wire logic [3:0] gpio_out
);
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside its slot");
   a_rdata_unmapped: assert property ($past(reg_rd)
      && ($past(reg_addr) & 4'h3) != 4'h0 |-> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_irq_global: assert property (xfer_irq |-> $past(global_irq_enable))
      else $error("interrupt without global enable");
   a_master_miso: assert property (sck_oe |-> !miso_oe)
      else $error("master drives miso");
   a_slave_quiet: assert property (miso_oe |-> !(mosi_oe || sck_oe || ss_n_oe))
      else $error("slave drives a pin other than miso");
   a_ss_plain: assert property (ss_n_oe && sck_oe |-> ss_n_out == gpio_out[3])
      else $error("select output not the user value");
   a_demote_pins: assert property (sck_oe && !ss_n_oe && !ss_n_in |-> ##[1:3] !sck_oe && !mosi_oe)
      else $error("no demotion on select low");
   a_ack_clear: assert property (irq_vector_ack |-> ##2 !xfer_irq)
      else $error("interrupt stays after vector entry");
endmodule
bind spimsp_top spimsp_asserts chk (.mclk, .srst, .reg_addr, .reg_rd,
   .reg_rdata, .global_irq_enable, .irq_vector_ack, .xfer_irq, .mosi_oe,
   .miso_oe, .sck_oe, .ss_n_in, .ss_n_out, .ss_n_oe, .gpio_out);
`default_nettype wire

/* File: tb/spimsp_top_test.sv */
// Purpose: Self-checking bench for the serial port block
// Assumes: Master frames use the peer, slave frames are bit-banged
// Notes: Slave sck phases of six clocks exceed the sync delay
`include "spimsp_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module spimsp_top_test;
   logic mclk = 0, srst = 1, reg_wr = 0, reg_rd = 0, clock_polarity = 0, clock_phase = 0;
   logic global_irq_enable = 0, irq_vector_ack = 0, lsb = 0, peer_miso;
   logic tb_sck = 0, tb_mosi = 0, tb_ss = 1, xfer_irq, mosi_out, mosi_oe;
   logic miso_out, miso_oe, sck_out, sck_oe, ss_n_out, ss_n_oe;
   logic [3:0] reg_addr = 4'h0, gpio_out = 4'h8;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, ptx = 8'h00, prx;
   logic [7:0] halves [8] = '{`SPIMSP_HALF_DIV4, `SPIMSP_HALF_DIV16,
      `SPIMSP_HALF_DIV64, `SPIMSP_HALF_DIV128, `SPIMSP_HALF_DIV2,
      `SPIMSP_HALF_DIV8, `SPIMSP_HALF_DIV32, `SPIMSP_HALF_DIV64};
   integer err_total = 0, cmp_count = 0, seed = 32'hd0aad90a;
   wire mosi_in = mosi_oe ? mosi_out : tb_mosi;
   wire miso_in = miso_oe ? miso_out : peer_miso;
   wire sck_in = sck_oe ? sck_out : tb_sck;
   wire ss_n_in = ss_n_oe ? ss_n_out : tb_ss;
   initial forever #4 mclk = ~mclk;
   spimsp_top dut (.mclk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .global_irq_enable, .irq_vector_ack, .xfer_irq, .mosi_in,
      .mosi_out, .mosi_oe, .miso_in, .miso_out, .miso_oe, .sck_in, .sck_out,
      .sck_oe, .ss_n_in, .ss_n_out, .ss_n_oe, .gpio_out);
   spimsp_peer peer (.sck(sck_in), .mosi(mosi_in), .ss_n(ss_n_in), .clock_polarity,
      .clock_phase, .lsb, .tx(ptx), .miso(peer_miso), .rx(prx));
   task report_and_stop;
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(negedge mclk);
      d = reg_rdata;
   endtask
   // Bounded wait for the next sck change, in clocks
   task sck_gap(output logic [7:0] n);
      logic s;
      s = sck_out;
      n = 8'h00;
      while (sck_out === s && n < 8'hF0) begin
         @(negedge mclk);
         n++;
      end
      if (n == 8'hF0) begin
         err_total++;
         report_and_stop;
      end
   endtask
   task sbits(input logic [7:0] b, input int nb, output logic [7:0] got);
      got = 8'h00;
      for (int i = 0; i < nb; i++) begin
         tb_mosi <= b[7 - i];
         repeat (6) @(posedge mclk);
         got = {got[6:0], miso_in};
         tb_sck <= 1'b1;
         repeat (6) @(posedge mclk);
         tb_sck <= 1'b0;
      end
      repeat (6) @(posedge mclk);
   endtask
   initial begin
      logic [7:0] s, r, n, d, g;
      repeat (20) @(posedge mclk);
      srst <= 1'b0;
      wr(4'h2, 8'hFF);
      for (int a = 0; a < 16; a += 2) begin
         rd(4'(a), r);
         chk(r, 8'h00);
      end
      $display("Test reset values done");
      for (int i = 0; i < 8; i++) begin
         {lsb, clock_polarity, clock_phase} = 3'(i);
         wr(4'hC, 8'h0D);
         wr(4'h0, {2'b01, lsb, 1'b1, clock_polarity, clock_phase, 2'(i)});
         wr(4'h4, {7'h00, lsb});
         gpio_out <= 4'h0;
         ptx = 8'($random(seed));
         d = 8'($random(seed));
         chk({7'h0, sck_out}, {7'h0, clock_polarity});
         wr(4'h8, d);
         chk({7'h0, ss_n_out}, 8'h00);
         sck_gap(n);
         sck_gap(n);
         chk(n, halves[i]);
         wr(4'h8, ~d);
         s = 8'h00;
         for (int k = 0; k < 600 && s[7] !== 1'b1; k++)
            rd(4'h4, s);
         chk(s & 8'hC0, 8'hC0);
         rd(4'h8, r);
         chk(r, ptx);
         chk(prx, d);
         rd(4'h4, s);
         chk(s & 8'hC0, 8'h00);
         chk({7'h0, sck_out}, {7'h0, clock_polarity});
         gpio_out <= 4'h8;
      end
      $display("Test master frames done");
      wr(4'hC, 8'h05);
      global_irq_enable <= 1'b1;
      wr(4'h0, 8'hD0);
      tb_ss <= 1'b0;
      repeat (4) @(negedge mclk);
      rd(4'h0, r);
      chk(r, 8'hC0);
      chk({6'h0, sck_oe, mosi_oe}, 8'h00);
      chk({7'h0, xfer_irq}, 8'h01);
      tb_ss <= 1'b1;
      repeat (8) @(posedge mclk);
      rd(4'h0, r);
      chk(r, 8'hC0);
      irq_vector_ack <= 1'b1;
      @(posedge mclk);
      irq_vector_ack <= 1'b0;
      repeat (3) @(negedge mclk);
      chk({7'h0, xfer_irq}, 8'h00);
      wr(4'h0, 8'hD0);
      repeat (3) @(negedge mclk);
      chk({7'h0, sck_oe}, 8'h01);
      $display("Test demotion done");
      wr(4'hC, 8'h02);
      wr(4'h0, 8'h43);
      d = 8'($random(seed));
      wr(4'h8, d);
      n = 8'($random(seed));
      tb_ss <= 1'b0;
      sbits(n, 8, g);
      chk(g, d);
      rd(4'h8, r);
      chk(r, n);
      tb_ss <= 1'b1;
      repeat (4) @(negedge mclk);
      chk({7'h0, miso_oe}, 8'h00);
      tb_ss <= 1'b0;
      sbits(~n, 3, g);
      tb_ss <= 1'b1;
      repeat (6) @(posedge mclk);
      tb_ss <= 1'b0;
      sbits(8'h96, 8, g);
      rd(4'h8, r);
      chk(r, 8'h96);
      tb_ss <= 1'b1;
      $display("Test slave frames done");
      report_and_stop;
   end
endmodule
`default_nettype wire
